// >>> verilog/hps_port.sv
`timescale 1ns/1ps
module hps_port
    import hps_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Mode and core side
    input wire logic host_port_sel,
    input wire logic service_req,
    input wire logic dma_mode,
    input wire logic [hps_pkg::HPS_NREGS*8-1:0] rd_regs,
    output logic [7:0] wr_data,
    output logic [2:0] wr_sel,
    output logic wr_stb,
    output logic dma_ack_stb,
    output logic irq_ack_stb,
    // Gpio control for the three dual-use pins
    input wire logic [2:0] gpio_dir,
    input wire logic [2:0] gpio_out,
    output logic [2:0] gpio_in,
    // Host pins
    input wire logic host_enable_n,
    input wire logic host_read_not_write,
    input wire logic [2:0] host_register_select,
    input wire logic host_acknowledge_n,
    input wire logic [7:0] host_data_bus_i,
    output logic [7:0] host_data_bus_o,
    output logic host_data_bus_oe,
    output logic host_service_request_n_o,
    output logic host_service_request_n_oe,
    output logic host_enable_n_o,
    output logic host_enable_n_oe,
    output logic host_acknowledge_n_o,
    output logic host_acknowledge_n_oe
);
    typedef struct packed {
        logic en_d;
        logic ack_d;
        logic rnw_d;
        logic [2:0] sel_d;
        logic [7:0] din_d;
        logic [7:0] wdat;
        logic [2:0] wsel;
        logic wstb;
        logic dstb;
        logic istb;
        logic [7:0] dout;
        logic doe;
        logic [1:0] req_o;
        logic [1:0] req_oe;
        logic [2:0] gpo;
        logic [2:0] gpoe;
        logic [2:0] gpi;
    } hps_state_t;

    hps_state_t st_ff;
    hps_state_t nxt_st;
    logic [2:0] pin_in;
    logic [2:0] idx;
    logic ack_act;

    assign pin_in = {host_acknowledge_n, 1'b1, host_enable_n};

    // Next state; every pin sample and output is a flop
    always_comb begin
        nxt_st = st_ff;
        nxt_st.en_d = host_enable_n;
        nxt_st.ack_d = host_acknowledge_n;
        nxt_st.rnw_d = host_read_not_write;
        nxt_st.sel_d = host_register_select;
        nxt_st.din_d = host_data_bus_i;
        nxt_st.wstb = 1'b0;
        nxt_st.dstb = 1'b0;
        nxt_st.istb = 1'b0;
        idx = host_register_select;
        ack_act = 1'b0;
        if (host_port_sel) begin
            // Acknowledge only counts while our request is out
            ack_act = !host_acknowledge_n && service_req;
            if (ack_act && !dma_mode) begin
                idx = HPS_VEC_SEL;
            end
            // Write: rising edge of enable with write selected
            if (!st_ff.en_d && host_enable_n && !st_ff.rnw_d) begin
                nxt_st.wdat = st_ff.din_d;
                nxt_st.wsel = st_ff.sel_d;
                nxt_st.wstb = 1'b1;
            end
            // Falling edge of acknowledge during request
            if (st_ff.ack_d && !host_acknowledge_n && service_req) begin
                nxt_st.dstb = dma_mode;
                nxt_st.istb = !dma_mode;
            end
            // Drive data on read strobe or acknowledge, else float
            nxt_st.doe = (!host_enable_n && host_read_not_write)
                || ack_act;
            nxt_st.dout = rd_regs[idx*8 +: 8];
            // Open drain: output always low, enable carries the level
            nxt_st.req_o = 2'b00;
            nxt_st.req_oe = {1'b0, service_req};
            nxt_st.gpoe = 3'b000;
        end else begin
            // Gpio mode; request pin is push-pull here
            nxt_st.doe = 1'b0;
            nxt_st.gpo = gpio_out;
            nxt_st.gpoe = gpio_dir;
            nxt_st.req_o = {1'b0, gpio_out[HPS_BIT_REQ]};
            nxt_st.req_oe = {1'b0, gpio_dir[HPS_BIT_REQ]};
        end
        nxt_st.gpi = {pin_in[2], 1'b0, pin_in[0]};
    end

    // State register; clock enable freezes everything except the synchronous reset
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.en_d <= 1'b1;
            st_ff.ack_d <= 1'b1;
            st_ff.dout <= HPS_DATA_RST;
            st_ff.wdat <= HPS_DATA_RST;
            st_ff.gpo <= HPS_GPIO_OUT_RST;
            st_ff.gpoe <= HPS_GPIO_DIR_RST;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops
    assign wr_data = st_ff.wdat;
    assign wr_sel = st_ff.wsel;
    assign wr_stb = st_ff.wstb;
    assign dma_ack_stb = st_ff.dstb;
    assign irq_ack_stb = st_ff.istb;
    assign gpio_in = st_ff.gpi;
    assign host_data_bus_o = st_ff.dout;
    assign host_data_bus_oe = st_ff.doe;
    assign host_service_request_n_o = st_ff.req_o[0];
    assign host_service_request_n_oe = st_ff.req_oe[0];
    assign host_enable_n_o = st_ff.gpo[HPS_BIT_EN];
    assign host_enable_n_oe = st_ff.gpoe[HPS_BIT_EN];
    assign host_acknowledge_n_o = st_ff.gpo[HPS_BIT_ACK];
    assign host_acknowledge_n_oe = st_ff.gpoe[HPS_BIT_ACK];

    // Checks
    a_write_capture: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && host_port_sel && !st_ff.en_d && host_enable_n
        && !st_ff.rnw_d |=> wr_stb && wr_data == $past(st_ff.din_d))
        else $error("write byte not captured");
    a_float_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && host_enable_n && !(host_port_sel && !host_acknowledge_n
        && service_req) |=> !host_data_bus_oe)
        else $error("data driven while idle");
    a_read_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && host_port_sel && !host_enable_n && host_read_not_write
        |=> host_data_bus_oe)
        else $error("read not driven");
    a_write_input: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && host_port_sel && !host_enable_n && !host_read_not_write
        && host_acknowledge_n |=> !host_data_bus_oe)
        else $error("driven on write");
    a_req_odrain: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(host_port_sel) && $past(clk_en)
        |-> !host_service_request_n_o)
        else $error("request driven high");
    a_ack_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && host_port_sel && !host_acknowledge_n && service_req
        |=> host_data_bus_oe)
        else $error("ack not driven");
    a_dma_ack: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && host_port_sel && dma_mode && service_req
        && st_ff.ack_d && !host_acknowledge_n |=> dma_ack_stb && !irq_ack_stb)
        else $error("dma ack lost");
    a_vec_ack: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && host_port_sel && !dma_mode && service_req
        && st_ff.ack_d && !host_acknowledge_n
        |=> irq_ack_stb && host_data_bus_o == rd_regs[HPS_VEC_SEL*8 +: 8])
        else $error("vector ack wrong");
    a_gpio_req: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && !host_port_sel |=> host_service_request_n_oe
        == $past(gpio_dir[HPS_BIT_REQ]))
        else $error("gpio request dir");
    a_gpio_reset: assert property (@(posedge ref_clk)
        !nrst |=> !host_enable_n_oe && !host_acknowledge_n_oe)
        else $error("gpio not input after reset");
    a_sel_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && host_port_sel && !st_ff.en_d && host_enable_n
        && !st_ff.rnw_d |=> wr_sel == $past(st_ff.sel_d))
        else $error("select not kept");
    c_write: cover property (@(posedge ref_clk) wr_stb);
    c_read: cover property (@(posedge ref_clk) host_data_bus_oe
        && !host_enable_n);
    c_dma: cover property (@(posedge ref_clk) dma_ack_stb);
    c_irq: cover property (@(posedge ref_clk) irq_ack_stb);
    c_gpio: cover property (@(posedge ref_clk) host_service_request_n_oe
        && host_service_request_n_o);

    // Request pull follows the core's level one cycle later
    a_req_pull: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && host_port_sel |=> host_service_request_n_oe
        == $past(service_req))
        else $error("request pull wrong");

    // An acknowledge with no request out must not raise a strobe;
    // a stray low level on the pin would otherwise look like a handshake
    a_ack_ignored: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && !service_req |=> !dma_ack_stb && !irq_ack_stb)
        else $error("stray ack taken");
endmodule

// >>> include/hps_pkg.sv
package hps_pkg;
    // Host register select width and data width
    localparam int HPS_SEL_W = 3;
    localparam int HPS_DATA_W = 8;
    localparam int HPS_NREGS = 8;
    // Reset values
    localparam logic [7:0] HPS_DATA_RST = 8'h00;
    localparam logic [2:0] HPS_GPIO_DIR_RST = 3'h0;
    localparam logic [2:0] HPS_GPIO_OUT_RST = 3'h0;
    // Bit positions of the three dual-use pins in the gpio vectors
    localparam int HPS_BIT_EN = 0;
    localparam int HPS_BIT_REQ = 1;
    localparam int HPS_BIT_ACK = 2;
    // Register index that the vectored acknowledge reads out
    localparam logic [2:0] HPS_VEC_SEL = 3'h3;
endpackage

// >>> test/hps_host_model.sv
`timescale 1ns/1ps
module hps_host_model (
    // Clock
    input wire logic ref_clk,
    // Device answers
    input wire logic [7:0] dat_o,
    input wire logic dat_oe,
    // Host drives
    output logic en_n,
    output logic rnw = 1'b1,
    output logic [2:0] sel = 3'h0,
    output logic ack_n = 1'b1,
    output logic [7:0] dat_i = 8'h5a
);
    logic cs = 1'b0;
    logic strb = 1'b0;
    // Enable is the decoded chip select gated by the access strobe
    assign en_n = ~(cs & strb);
    // One access; q holds what the device drove, x if it stayed off
    task automatic cyc(input logic r, input logic [2:0] s,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        cs <= 1'b1;
        strb <= 1'b1;
        rnw <= r;
        sel <= s;
        dat_i <= r ? ~d : d;
        repeat (2) @(posedge ref_clk);
        q = dat_oe ? dat_o : 8'hxx;
        strb <= 1'b0;
        cs <= 1'b0;
        // Released bus shows the inverse, never a stale copy
        @(posedge ref_clk);
        dat_i <= ~d;
    endtask
    // Acknowledge answering the service request
    task automatic ack(output logic [7:0] q);
        @(posedge ref_clk);
        ack_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        q = dat_oe ? dat_o : 8'hxx;
        ack_n <= 1'b1;
    endtask
endmodule

// >>> test/tb_hps_port.sv
`timescale 1ns/1ps
module tb_hps_port;
    import hps_pkg::*;
    typedef struct {logic [2:0] s; logic [7:0] w; logic [7:0] r;} hps_row_t;
    hps_row_t rows [4] = '{'{3'h0, 8'ha5, 8'h80}, '{3'h3, 8'h00, 8'hb3},
        '{3'h5, 8'hff, 8'hd5}, '{3'h7, 8'h3c, 8'hf7}};
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic svc = 1'b0;
    logic dma = 1'b0;
    logic [2:0] gdir = 3'h0;
    logic [2:0] gout = 3'h0;
    logic [7:0] wr_data, dat_o, dat_i, q;
    logic [2:0] wr_sel, sel, gin;
    logic wr_stb, dack, iack, dat_oe, req_o, req_oe, rnw;
    logic en_n, en_o, en_oe, en_w, ack_n, ack_o, ack_oe, ack_w;
    int error_cnt = 0;
    int compares = 0;
    int cyc_cnt = 0;
    int wr_cnt = 0;
    int dack_cnt = 0;
    int iack_cnt = 0;
    always #4 ref_clk = ~ref_clk;
    // Pin level resolves the gpio drive against the host drive
    assign en_w = en_oe ? en_o : en_n;
    assign ack_w = ack_oe ? ack_o : ack_n;
    hps_host_model host_u (.ref_clk(ref_clk), .dat_o(dat_o),
        .dat_oe(dat_oe), .en_n(en_n), .rnw(rnw), .sel(sel),
        .ack_n(ack_n), .dat_i(dat_i));
    hps_port dut_u (.ref_clk(ref_clk), .nrst(nrst), .clk_en(1'b1),
        .host_port_sel(psel), .service_req(svc), .dma_mode(dma),
        .rd_regs(64'hf7e6_d5c4_b3a2_9180), .wr_data(wr_data),
        .wr_sel(wr_sel), .wr_stb(wr_stb), .dma_ack_stb(dack),
        .irq_ack_stb(iack), .gpio_dir(gdir), .gpio_out(gout),
        .gpio_in(gin),
        .host_enable_n(en_w), .host_read_not_write(rnw),
        .host_register_select(sel), .host_acknowledge_n(ack_w),
        .host_data_bus_i(dat_i), .host_data_bus_o(dat_o),
        .host_data_bus_oe(dat_oe), .host_service_request_n_o(req_o),
        .host_service_request_n_oe(req_oe), .host_enable_n_o(en_o),
        .host_enable_n_oe(en_oe), .host_acknowledge_n_o(ack_o),
        .host_acknowledge_n_oe(ack_oe));
    // Pulses are counted, so a task may block through them
    always @(posedge ref_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        wr_cnt <= wr_cnt + (wr_stb === 1'b1);
        dack_cnt <= dack_cnt + (dack === 1'b1);
        iack_cnt <= iack_cnt + (iack === 1'b1);
        if (cyc_cnt == 3000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        #1 chk({dat_oe, req_oe, en_oe, ack_oe}, 4'h0);
        @(posedge ref_clk);
        nrst <= 1'b1;
        psel <= 1'b1;
        foreach (rows[i]) begin
            host_u.cyc(1'b0, rows[i].s, rows[i].w, q);
            repeat (3) @(posedge ref_clk);
            chk(wr_data, rows[i].w);
            chk(wr_sel, rows[i].s);
            host_u.cyc(1'b1, rows[i].s, 8'h00, q);
            chk(q, rows[i].r);
            repeat (2) @(posedge ref_clk);
            #1 chk(dat_oe, 1'b0);
            chk(gin, 3'h5);
        end
        chk(wr_cnt, 4);
        $display("table test done");
        // Acknowledge with no request pending must be ignored
        dma <= 1'b1;
        host_u.ack(q);
        chk(q, 8'hxx);
        svc <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 chk({req_oe, req_o}, 2'b10);
        host_u.ack(q);
        dma <= 1'b0;
        host_u.ack(q);
        chk(q, 8'hb3);
        repeat (2) @(posedge ref_clk);
        chk(dack_cnt, 1);
        chk(iack_cnt, 1);
        $display("ack test done");
        // Gpio mode: request pin must drive high as well as low
        psel <= 1'b0;
        svc <= 1'b0;
        gdir <= 3'h7;
        gout <= 3'h2;
        repeat (2) @(posedge ref_clk);
        #1 chk({req_oe, req_o, en_oe, en_o, ack_oe, ack_o}, 6'h3a);
        chk(gin, 3'h0);
        gout <= 3'h0;
        repeat (2) @(posedge ref_clk);
        #1 chk({req_oe, req_o}, 2'b10);
        $display("gpio test done");
        complete_run();
    end
endmodule
